// ==== hdl/slfm_fifo.sv ====
// Frame FIFO with width and depth parameters
`timescale 1ns/10ps
module slfm_fifo #(
  parameter int WIDTH = 360,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Honest flags from the occupancy count, no intake while in reset
  assign in_ready = rst_n && (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  // Storage write
  always_ff @(posedge clock)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  // Pointers and count
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // slfm_fifo

// ==== hdl/slfm_mapper.sv ====
// Sample frame mapper: packs channel samples into per-lane frames
`timescale 1ns/10ps
`include "slfm_regs.svh"
module slfm_mapper #(
  parameter int FIFO_DEPTH = `SLFM_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic resetn,
  input wire slfm_pkg::slfm_mode_t link_format_mode,
  input wire slfm_pkg::slfm_variant_t channel_variant,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [`SLFM_NCH*`SLFM_NSAMP*`SLFM_SAMPLE_W-1:0] sample_frame,
  output logic frame_valid,
  input wire logic frame_ready,
  output logic [`SLFM_NLANE-1:0] lane_enable,
  output logic [`SLFM_LANE_W-1:0] serial_lane_0,
  output logic [`SLFM_LANE_W-1:0] serial_lane_1,
  output logic [`SLFM_LANE_W-1:0] serial_lane_2,
  output logic [`SLFM_LANE_W-1:0] serial_lane_3,
  output logic [`SLFM_LANE_W-1:0] serial_lane_4,
  output logic [`SLFM_LANE_W-1:0] serial_lane_5,
  output logic [`SLFM_LANE_W-1:0] serial_lane_6,
  output logic [`SLFM_LANE_W-1:0] serial_lane_7
);
  localparam int FW = `SLFM_NCH * `SLFM_NSAMP * `SLFM_SAMPLE_W;
  logic rst_meta_q;
  logic rst_n;
  logic fifo_valid;
  logic take;
  logic [FW-1:0] fifo_data;
  logic [`SLFM_LANE_W-1:0] lane_d [`SLFM_NLANE];
  logic [`SLFM_LANE_W-1:0] lane_q [`SLFM_NLANE];
  logic [`SLFM_NLANE-1:0] en_d;
  logic [`SLFM_NLANE-1:0] en_q;
  logic valid_q;
  slfm_pkg::slfm_mode_t mode_q;
  slfm_pkg::slfm_variant_t var_q;

  // Reset release through two flops
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // Frame buffer ahead of the packer
  slfm_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data(sample_frame),
    .out_valid(fifo_valid),
    .out_ready(take),
    .out_data(fifo_data)
  );

  // Output stage stalls the FIFO under back-pressure
  assign take = fifo_valid && (!valid_q || frame_ready);

  // Sample n of channel ch from the frame word
  function automatic logic [`SLFM_SAMPLE_W-1:0] smp(
    input logic [FW-1:0] f,
    input int ch,
    input int n
  );
    return f[(ch * `SLFM_NSAMP + n) * `SLFM_SAMPLE_W +: `SLFM_SAMPLE_W];
  endfunction

  // Packing for both link formats
  always_comb
  begin
    logic [`SLFM_SAMPLE_W-1:0] x0;
    logic [`SLFM_SAMPLE_W-1:0] x1;
    logic [`SLFM_SAMPLE_W-1:0] y0;
    logic [`SLFM_SAMPLE_W-1:0] y1;
    logic grp_on;
    logic y_on;
    x0 = '0;
    x1 = '0;
    y0 = '0;
    y1 = '0;
    grp_on = 1'b0;
    y_on = 1'b0;
    en_d = '0;
    for (int l = 0; l < `SLFM_NLANE; l++)
      lane_d[l] = '0;
    unique case (link_format_mode)
      slfm_pkg::SLFM_MODE0:
      begin
        // Lane pair per channel, even then odd samples
        for (int l = 0; l < `SLFM_NLANE; l++)
        begin
          if ((l < `SLFM_M0_LANES_1CH)
              || (l < `SLFM_M0_LANES_2CH
                  && channel_variant != slfm_pkg::SLFM_SINGLE)
              || channel_variant == slfm_pkg::SLFM_QUAD)
          begin
            en_d[l] = 1'b1;
            for (int k = 0; k < `SLFM_M0_PER_LANE; k++)
              lane_d[l][`SLFM_LANE_W-1-k*`SLFM_SLOT_W -: `SLFM_SLOT_W] =
                {smp(fifo_data, l / 2, 2 * k + l % 2),
                 `SLFM_PAD_ZERO};
          end
        end
      end
      slfm_pkg::SLFM_MODE1:
      begin
        // Two lane groups: A with B, then C with D
        for (int g = 0; g < 2; g++)
        begin
          x0 = smp(fifo_data, 2 * g, 0);
          x1 = smp(fifo_data, 2 * g, 1);
          y0 = smp(fifo_data, 2 * g + 1, 0);
          y1 = smp(fifo_data, 2 * g + 1, 1);
          grp_on = (g == 0) || (channel_variant == slfm_pkg::SLFM_QUAD);
          y_on = channel_variant != slfm_pkg::SLFM_SINGLE;
          if (grp_on)
          begin
            en_d[3*g] = 1'b1;
            en_d[3*g+1] = 1'b1;
            en_d[3*g+2] = y_on;
            lane_d[3*g][`SLFM_LANE_W-1 -: `SLFM_M1_W] =
              {x0, `SLFM_PAD_ZERO,
               x1[`SLFM_SAMPLE_W-1:`SLFM_M1_SPLIT]};
            lane_d[3*g+1][`SLFM_LANE_W-1 -: `SLFM_M1_W] =
              {x1[`SLFM_M1_SPLIT-1:0], `SLFM_PAD_ZERO,
               y_on ? y0[`SLFM_SAMPLE_W-1 -: `SLFM_BYTE_W]
                    : `SLFM_BYTE_ZERO};
            if (y_on)
              lane_d[3*g+2][`SLFM_LANE_W-1 -: `SLFM_M1_W] =
                {y0[0], `SLFM_PAD_ZERO, y1, `SLFM_PAD_ZERO};
          end
        end
      end
    endcase
  end

  // Output frame register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int l = 0; l < `SLFM_NLANE; l++)
        lane_q[l] <= '0;
      en_q <= '0;
      mode_q <= slfm_pkg::SLFM_MODE0;
      var_q <= slfm_pkg::SLFM_SINGLE;
    end
    else if (take)
    begin
      for (int l = 0; l < `SLFM_NLANE; l++)
        lane_q[l] <= lane_d[l];
      en_q <= en_d;
      mode_q <= link_format_mode;
      var_q <= channel_variant;
    end
  end

  // Frame valid flag
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      valid_q <= 1'b0;
    else if (take)
      valid_q <= 1'b1;
    else if (frame_ready)
      valid_q <= 1'b0;
  end

  assign frame_valid = valid_q;
  assign lane_enable = en_q;
  assign serial_lane_0 = lane_q[0];
  assign serial_lane_1 = lane_q[1];
  assign serial_lane_2 = lane_q[2];
  assign serial_lane_3 = lane_q[3];
  assign serial_lane_4 = lane_q[4];
  assign serial_lane_5 = lane_q[5];
  assign serial_lane_6 = lane_q[6];
  assign serial_lane_7 = lane_q[7];

  // Checks on the packed output
  property p_tail_zero;
    @(posedge clock) disable iff (!rst_n)
      (mode_q == slfm_pkg::SLFM_MODE0)
      |-> (lane_q[0][`SLFM_TAIL_W-1:0] == `SLFM_TAIL_ZERO);
  endproperty
  a_tail_zero: assert property (p_tail_zero)
    else $error("mode 0 tail bits not zero");

  property p_pad_zero;
    @(posedge clock) disable iff (!rst_n)
      (mode_q == slfm_pkg::SLFM_MODE0)
      |-> (lane_q[1][54:52] == `SLFM_PAD_ZERO);
  endproperty
  a_pad_zero: assert property (p_pad_zero)
    else $error("mode 0 slot padding not zero");

  property p_quad_lanes;
    @(posedge clock) disable iff (!rst_n)
      (take && link_format_mode == slfm_pkg::SLFM_MODE0
       && channel_variant == slfm_pkg::SLFM_QUAD) |=> (en_q == 8'hff);
  endproperty
  a_quad_lanes: assert property (p_quad_lanes)
    else $error("mode 0 quad does not enable eight lanes");

  property p_m1_short;
    @(posedge clock) disable iff (!rst_n)
      (mode_q == slfm_pkg::SLFM_MODE1)
      |-> (lane_q[0][`SLFM_LANE_W-`SLFM_M1_W-1:0] == '0) && !en_q[6];
  endproperty
  a_m1_short: assert property (p_m1_short)
    else $error("mode 1 frame wider than two octets");

  property p_m1_single;
    @(posedge clock) disable iff (!rst_n)
      (mode_q == slfm_pkg::SLFM_MODE1 && var_q == slfm_pkg::SLFM_SINGLE)
      |-> (lane_q[1][55:48] == `SLFM_BYTE_ZERO) && (en_q == 8'h03);
  endproperty
  a_m1_single: assert property (p_m1_single)
    else $error("mode 1 single lane 1 byte not zero");

  property p_m1_lane2;
    @(posedge clock) disable iff (!rst_n)
      (mode_q == slfm_pkg::SLFM_MODE1 && var_q == slfm_pkg::SLFM_DUAL)
      |-> (lane_q[2][62:60] == `SLFM_PAD_ZERO)
          && (lane_q[2][50:48] == `SLFM_PAD_ZERO);
  endproperty
  a_m1_lane2: assert property (p_m1_lane2)
    else $error("mode 1 lane 2 padding not zero");

  property p_off_lane_zero;
    @(posedge clock) disable iff (!rst_n)
      !en_q[7] |-> (lane_q[7] == '0);
  endproperty
  a_off_lane_zero: assert property (p_off_lane_zero)
    else $error("powered down lane carries data");

  property p_hold;
    @(posedge clock) disable iff (!rst_n)
      (valid_q && !frame_ready) |=> valid_q && $stable(lane_q[0]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("frame changed while stalled");

  property p_latency;
    @(posedge clock) disable iff (!rst_n)
      take |=> valid_q && (en_q == $past(en_d));
  endproperty
  a_latency: assert property (p_latency)
    else $error("frame not presented one cycle after take");
endmodule // slfm_mapper

// ==== hdl/slfm_pkg.sv ====
// Types for the sample frame mapper
package slfm_pkg;
  typedef enum logic { SLFM_MODE0, SLFM_MODE1 } slfm_mode_t;
  typedef enum logic [1:0] { SLFM_SINGLE, SLFM_DUAL, SLFM_QUAD } slfm_variant_t;
endpackage

// ==== hdl/slfm_regs.svh ====
// Layout constants for the sample frame mapper
`ifndef SLFM_REGS_SVH
`define SLFM_REGS_SVH
`define SLFM_SAMPLE_W 9
`define SLFM_PAD_W 3
`define SLFM_SLOT_W 12
`define SLFM_TAIL_W 4
`define SLFM_LANE_W 64
`define SLFM_M1_W 16
`define SLFM_M1_TOP 15
`define SLFM_NCH 4
`define SLFM_NSAMP 10
`define SLFM_M0_PER_LANE 5
`define SLFM_NLANE 8
`define SLFM_M0_LANES_1CH 2
`define SLFM_M0_LANES_2CH 4
`define SLFM_M1_SPLIT 5
`define SLFM_BYTE_W 8
`define SLFM_FIFO_DEPTH 16
`define SLFM_BYTE_ZERO 8'h00
`define SLFM_PAD_ZERO 3'h0
`define SLFM_TAIL_ZERO 4'h0
`endif

// ==== test/slfm_rx_model.sv ====
// Link receiver model that takes packed frames
`timescale 1ns/10ps
module slfm_rx_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic stall,
  input wire logic frame_valid,
  output logic frame_ready,
  output int taken
);
  // Ready withdrawn while stalled
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      frame_ready <= 1'b0;
    else
      frame_ready <= !stall;
  end
  // Frames counted in arrival order for time order
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      taken <= 0;
    else if (frame_valid && frame_ready)
      taken <= taken + 1;
  end
endmodule // slfm_rx_model

// ==== test/tb.sv ====
// Testbench for the sample frame mapper
`timescale 1ns/10ps
`include "slfm_regs.svh"
module tb;
  localparam int FW = `SLFM_NCH*`SLFM_NSAMP*`SLFM_SAMPLE_W;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  slfm_pkg::slfm_mode_t mode = slfm_pkg::SLFM_MODE0;
  slfm_pkg::slfm_variant_t variant = slfm_pkg::SLFM_SINGLE;
  logic sample_valid = 1'b0;
  logic stall = 1'b1;
  logic sample_ready, frame_valid, frame_ready;
  logic [FW-1:0] sample_frame = '0;
  logic [7:0] lane_enable;
  logic [63:0] lanes [8];
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  int refusals = 0;
  int taken;

  slfm_mapper #(.FIFO_DEPTH(4)) u_dut (.clock(clock), .resetn(resetn),
    .link_format_mode(mode), .channel_variant(variant),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_frame(sample_frame), .frame_valid(frame_valid),
    .frame_ready(frame_ready), .lane_enable(lane_enable),
    .serial_lane_0(lanes[0]), .serial_lane_1(lanes[1]),
    .serial_lane_2(lanes[2]), .serial_lane_3(lanes[3]),
    .serial_lane_4(lanes[4]), .serial_lane_5(lanes[5]),
    .serial_lane_6(lanes[6]), .serial_lane_7(lanes[7]));
  slfm_rx_model u_rx (.clock(clock), .resetn(resetn), .stall(stall),
    .frame_valid(frame_valid), .frame_ready(frame_ready), .taken(taken));

  // Clock and hang guard
  always #4 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      summarize();
    end
  end

  function automatic logic [8:0] smp(logic [FW-1:0] f, int ch, int n);
    return f[(ch*10+n)*9 +: 9];
  endfunction
  function automatic logic [FW-1:0] mk(int s);
    logic [FW-1:0] f;
    for (int i = 0; i < 40; i++)
      f[i*9 +: 9] = 9'((s*37 + i*13 + 5) % 512);
    return f;
  endfunction
  function automatic int nlanes(logic m, logic [1:0] v);
    if (m == 1'b0)
      return (v == 2'h0) ? 2 : (v == 2'h1) ? 4 : 8;
    return (v == 2'h0) ? 2 : (v == 2'h1) ? 3 : 6;
  endfunction
  // Expected lane word: mode 0 five slots, mode 1 top 16 bits
  function automatic logic [63:0] exp_lane(logic m, logic [1:0] v,
    logic [FW-1:0] f, int l);
    logic [63:0] w;
    logic [8:0] x0, x1, y0, y1;
    int g;
    w = 64'h0;
    g = 2 * (l / 3);
    x0 = smp(f, g, 0);
    x1 = smp(f, g, 1);
    y0 = (v == 2'h0) ? 9'h000 : smp(f, g + 1, 0);
    y1 = smp(f, g + 1, 1);
    if (m == 1'b0)
      for (int k = 0; k < 5; k++)
        w[63-12*k -: 12] = {smp(f, l/2, 2*k + l%2), 3'h0};
    else if (l % 3 == 0)
      w[63:48] = {x0, 3'h0, x1[8:5]};
    else if (l % 3 == 1)
      w[63:48] = {x1[4:0], 3'h0, y0[8:1]};
    else
      w[63:48] = {y0[0], 3'h0, y1, 3'h0};
    return (l < nlanes(m, v)) ? w : 64'h0;
  endfunction

  task automatic chk(logic [63:0] got, logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_frame(logic [FW-1:0] f, logic m, logic [1:0] v);
    for (int l = 0; l < 8; l++)
      chk(lanes[l], exp_lane(m, v, f, l));
    chk(64'(lane_enable), 64'((1 << nlanes(m, v)) - 1));
  endtask
  // Offer one frame; held until taken, stall lifted after refusals
  task automatic push(logic [FW-1:0] f);
    sample_valid <= 1'b1;
    sample_frame <= f;
    @(negedge clock);
    while (sample_ready !== 1'b1)
    begin
      @(posedge clock);
      refusals++;
      if (refusals == 4)
        stall <= 1'b0;
      @(negedge clock);
    end
    @(posedge clock);
  endtask
  task automatic wait_out();
    int n;
    n = 0;
    @(negedge clock);
    while (frame_valid !== 1'b1 && n < 50)
    begin
      @(negedge clock);
      n++;
    end
    chk(64'(frame_valid), 64'h1);
  endtask

  task automatic sc_reset();
    @(negedge clock);
    chk(64'(frame_valid), 64'h0);
    chk(64'(lane_enable), 64'h0);
    chk(64'(sample_ready), 64'h0);
  endtask
  // Every mode and variant once
  task automatic sc_modes();
    stall <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      mode <= slfm_pkg::slfm_mode_t'(i / 3);
      variant <= slfm_pkg::slfm_variant_t'(i % 3);
      push(mk(i));
      sample_valid <= 1'b0;
      wait_out();
      check_frame(mk(i), 1'(i / 3), 2'(i % 3));
      @(posedge clock);
    end
  endtask
  // Back-to-back frames into a stalled receiver, then drain in order
  task automatic sc_fill();
    stall <= 1'b1;
    mode <= slfm_pkg::SLFM_MODE0;
    variant <= slfm_pkg::SLFM_QUAD;
    @(posedge clock);
    fork
      begin
        for (int i = 0; i < 8; i++)
          push(mk(10 + i));
        sample_valid <= 1'b0;
      end
      for (int j = 0; j < 8; j++)
      begin
        @(negedge clock);
        while (!(frame_valid === 1'b1 && frame_ready === 1'b1))
          @(negedge clock);
        check_frame(mk(10 + j), 1'b0, 2'h2);
      end
    join
    chk(64'(refusals >= 4), 64'h1);
    // Last frame is counted by the receiver at the next edge
    @(negedge clock);
    chk(64'(taken), 64'd14);
  endtask

  task automatic summarize();
    $display("Mismatches %0d of %0d checks", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clock);
    sc_reset();
    @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    sc_modes();
    sc_fill();
    summarize();
  end
endmodule // tb
